/* File: core/ccao_pkg.sv */
/*
  shared constants and carriers for the compare/clear/adjust/divide unit
  assumes the core supplies fetched opcode bytes and operand values
*/
package ccao_pkg;

  // opcodes
  localparam logic [7:0] OP_CBNE_A_IMM  = 8'hb4;
  localparam logic [7:0] OP_CBNE_A_DIR  = 8'hb5;
  localparam logic [4:0] OP_CBNE_RN_HI  = 5'h17;
  localparam logic [6:0] OP_CBNE_IND_HI = 7'h5b;
  localparam logic [7:0] OP_ZERO_A      = 8'he4;
  localparam logic [7:0] OP_ZERO_C      = 8'hc3;
  localparam logic [7:0] OP_ZERO_BIT    = 8'hc2;
  localparam logic [7:0] OP_INV_A       = 8'hf4;
  localparam logic [7:0] OP_INV_C       = 8'hb3;
  localparam logic [7:0] OP_INV_BIT     = 8'hb2;
  localparam logic [7:0] OP_BCD_FIX     = 8'hd4;
  localparam logic [7:0] OP_DEC_A       = 8'h14;
  localparam logic [7:0] OP_DEC_DIR     = 8'h15;
  localparam logic [4:0] OP_DEC_RN_HI   = 5'h03;
  localparam logic [6:0] OP_DEC_IND_HI  = 7'h0b;
  localparam logic [7:0] OP_DIV         = 8'h84;

  // byte and cycle counts
  localparam logic [2:0] CBNE_BYTES = 3'h3;
  localparam logic [2:0] CBNE_CYC   = 3'h2;
  localparam logic [2:0] DIV_CYC    = 3'h4;
  localparam logic [2:0] ONE_CYC    = 3'h1;
  localparam logic [2:0] ONE_BYTE   = 3'h1;
  localparam logic [2:0] TWO_BYTES  = 3'h2;

  // bcd adjust constants
  localparam logic [3:0] BCD_MAX    = 4'h9;
  localparam logic [3:0] BCD_STEP   = 4'h6;

  // reset values
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [7:0]  HLP_RST   = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;

  // flag word: carry, aux_carry, overflow
  typedef struct packed {
    logic cy;
    logic ac;
    logic ov;
  } ccao_flags_t;

  // instruction request from fetch
  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    logic [7:0] imm;
    logic [7:0] rel;
    logic [7:0] mem;
    logic [7:0] latch;
    logic       bit_val;
  } ccao_req_t;

  // write-back towards register file, ram and ports
  typedef struct packed {
    logic       byte_we;
    logic [7:0] byte_val;
    logic       bit_we;
    logic       bit_val;
  } ccao_wb_t;

endpackage

/* File: core/ccao_divider.sv */
/*
  unsigned 8-bit divider, quotient and remainder formed in one step
  assumes start is a one-cycle pulse; results stand until the next start
*/
`timescale 1ns/1ns
module ccao_divider
  import ccao_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // request
  input  wire logic       start,
  input  wire logic [7:0] dividend,
  input  wire logic [7:0] divisor,
  // result
  output logic            done,
  output logic [7:0]      quot,
  output logic [7:0]      rem
);

  logic [7:0] quot_q;
  logic [7:0] rem_q;
  logic       done_q;
  logic [7:0] quot_d;
  logic [8:0] part;

  assign done = done_q;
  assign quot = quot_q;
  assign rem  = rem_q;

  // restoring division unrolled over all eight quotient bits; a zero
  // divisor gives ff and the dividend, never an unknown
  always_comb
  begin
    part   = 9'h000;
    quot_d = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      part = {part[7:0], dividend[i]};
      if (part >= {1'b0, divisor})
      begin
        part      = part - {1'b0, divisor};
        quot_d[i] = 1'b1;
      end
    end
  end

  // done marks that quot and rem belong to the last start
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      quot_q <= 8'h00;
      rem_q  <= 8'h00;
      done_q <= 1'b0;
    end
    else if (start)
    begin
      quot_q <= quot_d;
      rem_q  <= part[7:0];
      done_q <= 1'b1;
    end
  end

endmodule

/* File: core/ccao_exec.sv */
/*
  execution unit for compare-branch, clear, complement, bcd adjust,
  decrement and divide instructions
  assumes fetch holds req stable until done and supplies operand bytes;
  mem carries the addressed byte (sampled port data for compares),
  latch carries the port output latch for read-modify-write targets
*/
//
// What this block does
// - compare-branch: pc plus 3, add rel if unequal
// - immediate compares set carry when operand smaller
// - compare-branch is 3 bytes, 2 cycles
// - decode the three immediate compare forms
// - clear accumulator, flags kept, one cycle
// - clear carry or addressed bit, one cycle
// - complement accumulator, flags kept, one cycle
// - complement carry or addressed bit, one cycle
// - port modify reads output latch, not pins
// - low nibble adjust, carry only set
// - high nibble adjust, overflow flag kept
// - bcd adjust one byte, one cycle
// - decrement wraps, no flag change
// - decrement four operand forms, one cycle
// - divide: quotient to acc, remainder to helper
// - divide by zero sets overflow flag
// - divide one byte, four cycles
// - unsigned compare, operands unchanged
`timescale 1ns/1ns
module ccao_exec
  import ccao_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // instruction in
  input  wire ccao_req_t   req,
  input  wire logic [7:0]  acc_in,
  input  wire logic [7:0]  helper_in,
  input  wire ccao_flags_t flags_in,
  input  wire logic [15:0] pc_in,
  input  wire logic        port_target,
  // results
  output ccao_wb_t         wb,
  output logic [7:0]       acc_out,
  output logic             acc_we,
  output logic [7:0]       helper_out,
  output logic             helper_we,
  output ccao_flags_t      flags_out,
  output logic             flags_we,
  output logic [15:0]      pc_out,
  output logic             pc_we,
  output logic [2:0]       instr_bytes,
  output logic             done,
  output logic             illegal
);

  typedef enum logic [1:0] {S_IDLE, S_CMP2, S_DIV} ccao_state_t;

  ccao_state_t state_q;
  ccao_state_t state_d;
  logic [2:0]  cyc_q;

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic [7:0] op;
  assign op = req.opcode;

  wire is_cbne_a_imm = (op == OP_CBNE_A_IMM);
  wire is_cbne_rn    = (op[7:3] == OP_CBNE_RN_HI);
  wire is_cbne_ind   = (op[7:1] == OP_CBNE_IND_HI);
  wire is_cbne_a_dir = (op == OP_CBNE_A_DIR);
  wire is_cbne       = is_cbne_a_imm | is_cbne_rn | is_cbne_ind
                     | is_cbne_a_dir;
  wire is_zero_a     = (op == OP_ZERO_A);
  wire is_zero_c     = (op == OP_ZERO_C);
  wire is_zero_bit   = (op == OP_ZERO_BIT);
  wire is_inv_a      = (op == OP_INV_A);
  wire is_inv_c      = (op == OP_INV_C);
  wire is_inv_bit    = (op == OP_INV_BIT);
  wire is_bcd        = (op == OP_BCD_FIX);
  wire is_dec_a      = (op == OP_DEC_A);
  wire is_dec_dir    = (op == OP_DEC_DIR);
  wire is_dec_rn     = (op[7:3] == OP_DEC_RN_HI);
  wire is_dec_ind    = (op[7:1] == OP_DEC_IND_HI);
  wire is_div        = (op == OP_DIV);
  wire is_known      = is_cbne | is_zero_a | is_zero_c | is_zero_bit
                     | is_inv_a | is_inv_c | is_inv_bit | is_bcd
                     | is_dec_a | is_dec_dir | is_dec_rn | is_dec_ind
                     | is_div;

  ////////////////////////////////////////////////////////////////////////
  // compare-branch datapath

  // first operand: acc for acc forms, else register/indirect byte
  wire [7:0] cmp_lhs = (is_cbne_a_imm | is_cbne_a_dir) ? acc_in : req.mem;
  // direct form compares against the directly addressed byte
  wire [7:0] cmp_rhs = is_cbne_a_dir ? req.mem : req.imm;
  wire       cmp_ne  = (cmp_lhs != cmp_rhs);
  wire       cmp_lt  = (cmp_lhs < cmp_rhs);
  wire [15:0] pc_next = pc_in + 16'(CBNE_BYTES);
  wire [15:0] pc_br   = pc_next + {{8{req.rel[7]}}, req.rel};

  ////////////////////////////////////////////////////////////////////////
  // bcd adjust

  wire       lo_fix  = (acc_in[3:0] > BCD_MAX) | flags_in.ac;
  wire [8:0] bcd_s1  = {1'b0, acc_in} + (lo_fix ? {5'h00, BCD_STEP} : 9'h000);
  wire       cy1     = flags_in.cy | bcd_s1[8];
  wire       hi_fix  = cy1 | (bcd_s1[7:4] > BCD_MAX);
  wire [8:0] bcd_s2  = {1'b0, bcd_s1[7:0]}
                     + (hi_fix ? {1'b0, BCD_STEP, 4'h0} : 9'h000);
  wire       bcd_cy  = cy1 | bcd_s2[8];

  ////////////////////////////////////////////////////////////////////////
  // read-modify-write source: port targets use the output latch

  wire [7:0] rmw_byte = port_target ? req.latch : req.mem;
  wire       rmw_bit  = port_target ? req.latch[0] : req.bit_val;

  ////////////////////////////////////////////////////////////////////////
  // divider

  logic       div_start;
  logic       div_done;
  logic [7:0] div_quot;
  logic [7:0] div_rem;
  wire        div_zero = (helper_in == 8'h00);

  assign div_start = req.valid && is_div && (state_q == S_IDLE);

  ccao_divider u_div (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .start    (div_start),
    .dividend (acc_in),
    .divisor  (helper_in),
    .done     (div_done),
    .quot     (div_quot),
    .rem      (div_rem)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencing

  wire start_now = req.valid && (state_q == S_IDLE);
  wire div_last  = (state_q == S_DIV) && (cyc_q == DIV_CYC - 3'h1)
                 && div_done;
  wire cmp_last  = (state_q == S_CMP2);
  wire one_last  = start_now && is_known && !is_cbne && !is_div;
  wire fin       = one_last | cmp_last | div_last;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:
        if (req.valid && is_cbne)
          state_d = S_CMP2;
        else if (req.valid && is_div)
          state_d = S_DIV;
      S_CMP2: state_d = S_IDLE;
      S_DIV:  if (div_last) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  // the divider registers its result at the take edge; the counter
  // only paces the four machine cycles of a divide
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= S_IDLE;
      cyc_q   <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      cyc_q   <= (state_q == S_IDLE) ? ONE_CYC : cyc_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result selection

  ccao_wb_t    wb_d;
  ccao_flags_t fl_d;
  logic [7:0]  acc_d;
  logic [7:0]  hlp_d;
  logic        acc_we_d;
  logic        hlp_we_d;
  logic        fl_we_d;
  logic        pc_we_d;
  logic [15:0] pc_d;
  logic [2:0]  bytes_d;

  always_comb
  begin
    wb_d     = '0;
    fl_d     = flags_in;
    acc_d    = acc_in;
    hlp_d    = helper_in;
    acc_we_d = 1'b0;
    hlp_we_d = 1'b0;
    fl_we_d  = 1'b0;
    pc_we_d  = 1'b0;
    pc_d     = pc_in;
    bytes_d  = ONE_BYTE;
    if (cmp_last)
    begin
      pc_we_d = 1'b1;
      pc_d    = cmp_ne ? pc_br : pc_next;
      fl_d.cy = cmp_lt;
      fl_we_d = 1'b1;
      bytes_d = CBNE_BYTES;
    end
    else if (div_last)
    begin
      fl_d.cy  = 1'b0;
      fl_d.ov  = div_zero;
      fl_we_d  = 1'b1;
      acc_d    = div_quot;
      hlp_d    = div_rem;
      acc_we_d = !div_zero;
      hlp_we_d = !div_zero;
    end
    else if (one_last)
    begin
      if (is_zero_a)
      begin
        acc_d    = 8'h00;
        acc_we_d = 1'b1;
      end
      else if (is_inv_a)
      begin
        acc_d    = ~acc_in;
        acc_we_d = 1'b1;
      end
      else if (is_zero_c | is_inv_c)
      begin
        fl_d.cy = is_inv_c & ~flags_in.cy;
        fl_we_d = 1'b1;
      end
      else if (is_zero_bit | is_inv_bit)
      begin
        wb_d.bit_we  = 1'b1;
        wb_d.bit_val = is_inv_bit & ~rmw_bit;
        bytes_d      = TWO_BYTES;
      end
      else if (is_bcd)
      begin
        acc_d    = bcd_s2[7:0];
        acc_we_d = 1'b1;
        fl_d.cy  = bcd_cy;
        fl_we_d  = 1'b1;
      end
      else if (is_dec_a)
      begin
        acc_d    = acc_in - 8'h01;
        acc_we_d = 1'b1;
      end
      else
      begin
        wb_d.byte_we  = 1'b1;
        wb_d.byte_val = rmw_byte - 8'h01;
        bytes_d       = is_dec_dir ? TWO_BYTES : ONE_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wb          <= '0;
      acc_out     <= ACC_RST;
      acc_we      <= 1'b0;
      helper_out  <= HLP_RST;
      helper_we   <= 1'b0;
      flags_out   <= '0;
      flags_we    <= 1'b0;
      pc_out      <= PC_RST;
      pc_we       <= 1'b0;
      instr_bytes <= 3'h0;
      done        <= 1'b0;
      illegal     <= 1'b0;
    end
    else
    begin
      wb          <= wb_d;
      acc_out     <= acc_d;
      acc_we      <= acc_we_d;
      helper_out  <= hlp_d;
      helper_we   <= hlp_we_d;
      flags_out   <= fl_d;
      flags_we    <= fl_we_d;
      pc_out      <= pc_d;
      pc_we       <= pc_we_d;
      instr_bytes <= bytes_d;
      done        <= fin;
      illegal     <= start_now && !is_known;
    end
  end

endmodule

/* File: test/ccao_exec_asserts.sv */
/* checker: cycle counts and results of ccao_exec
   assumes a bind to ccao_exec and the hand-over timing */
`timescale 1ns/1ns
module ccao_exec_asserts
  import ccao_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  // request side
  input wire ccao_req_t   req,
  input wire logic [7:0]  acc_in,
  input wire logic [7:0]  helper_in,
  input wire ccao_flags_t flags_in,
  input wire logic [15:0] pc_in,
  // results
  input wire logic [7:0]  acc_out,
  input wire ccao_flags_t flags_out,
  input wire logic        flags_we,
  input wire logic [15:0] pc_out,
  input wire logic        pc_we,
  input wire logic [2:0]  instr_bytes,
  input wire logic        done,
  input wire logic        illegal
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [7:0]  op;
  logic [7:0]  opa;
  logic [7:0]  opb;
  logic [15:0] npc;
  logic        take;
  logic        is_cb;
  logic        busy_q;
  logic [15:0] pc_q;
  logic        cy_q;
  assign op    = req.opcode;
  assign take  = req.valid && (!busy_q || done || illegal);
  assign is_cb = op == OP_CBNE_A_IMM || op == OP_CBNE_A_DIR
              || op[7:3] == OP_CBNE_RN_HI || op[7:1] == OP_CBNE_IND_HI;
  assign opa   = (op == OP_CBNE_A_IMM || op == OP_CBNE_A_DIR) ? acc_in
                                                               : req.mem;
  assign opb   = (op == OP_CBNE_A_DIR) ? req.mem : req.imm;
  assign npc   = pc_in + 16'h0003
               + ((opa != opb) ? {{8{req.rel[7]}}, req.rel} : 16'h0000);
  // expected compare outcome, captured when the request is taken
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_q <= 1'b0;
      pc_q   <= 16'h0000;
      cy_q   <= 1'b0;
    end
    else
    begin
      busy_q <= take || (busy_q && !done && !illegal);
      if (take)
      begin
        pc_q <= npc;
        cy_q <= opa < opb;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_zero_acc: assert property (
    take && op == OP_ZERO_A |=> done && acc_out == 8'h00
    && (!flags_we || flags_out == $past(flags_in)))
    else $error("clear accumulator result wrong");
  a_inv_acc: assert property (
    take && op == OP_INV_A |=> done && acc_out == ~$past(acc_in))
    else $error("complement accumulator result wrong");
  a_dec_wrap: assert property (
    take && op == OP_DEC_A |=> done && acc_out == $past(acc_in) - 8'h01
    && (!flags_we || flags_out == $past(flags_in)))
    else $error("decrement accumulator result wrong");
  a_bcd_ov: assert property (
    take && op == OP_BCD_FIX |=> done && flags_out.ov == $past(flags_in.ov))
    else $error("decimal adjust timing or overflow flag wrong");
  a_cbne_len: assert property (
    take && is_cb |=> !done ##1 done && pc_we && instr_bytes == 3'h3)
    else $error("compare branch length or timing wrong");
  a_cbne_pc: assert property (
    done && pc_we |-> pc_out == pc_q)
    else $error("compare branch target wrong");
  a_cbne_carry: assert property (
    done && pc_we |-> flags_we && flags_out.cy == cy_q)
    else $error("compare branch carry wrong");
  a_div_len: assert property (
    take && op == OP_DIV |=> !done [*3] ##1 done)
    else $error("divide cycle count wrong");
  a_div_flags: assert property (
    take && op == OP_DIV |-> ##4 flags_we && !flags_out.cy
    && flags_out.ov == ($past(helper_in, 4) == 8'h00))
    else $error("divide flags wrong");
  a_div_result: assert property (
    take && op == OP_DIV && helper_in != 8'h00 |-> ##4
    acc_out == $past(acc_in, 4) / $past(helper_in, 4))
    else $error("divide quotient wrong");
  cover property (take && is_cb);
  cover property (take && op == OP_DIV && helper_in == 8'h00);
  cover property (take && op == OP_BCD_FIX);
endmodule

bind ccao_exec ccao_exec_asserts i_chk (
  .clk_sys(clk_sys), .nrst(nrst), .req(req), .acc_in(acc_in),
  .helper_in(helper_in), .flags_in(flags_in), .pc_in(pc_in),
  .acc_out(acc_out), .flags_out(flags_out), .flags_we(flags_we),
  .pc_out(pc_out), .pc_we(pc_we), .instr_bytes(instr_bytes),
  .done(done), .illegal(illegal)
);

/* File: test/tb_top.sv */
/* testbench: directed instruction sequences for ccao_exec
   assumes the checker is bound in from its own file */
`timescale 1ns/1ns
module tb_top import ccao_pkg::*;;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  ccao_req_t   req = '0;
  logic [7:0]  acc_in = 8'h00;
  logic [7:0]  helper_in = 8'h00;
  ccao_flags_t flags_in = '0;
  logic [15:0] pc_in = 16'h0000;
  logic        port_target = 1'b0;
  ccao_wb_t    wb;
  logic [7:0]  acc_out;
  logic [7:0]  helper_out;
  ccao_flags_t flags_out;
  logic [15:0] pc_out;
  logic [2:0]  instr_bytes;
  logic        acc_we;
  logic        helper_we;
  logic        flags_we;
  logic        pc_we;
  logic        done;
  logic        illegal;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc;
  logic [7:0]  x;
  logic [7:0]  y;
  logic [7:0]  cop [4] = '{8'hb4, 8'hb5, 8'hbd, 8'hb7};
  logic [7:0]  ca [3] = '{8'h56, 8'h34, 8'hfb};
  logic [7:0]  cb [3] = '{8'h60, 8'h34, 8'h12};
  logic [7:0]  ba [6] = '{8'hbe, 8'hc9, 8'h19, 8'h9a, 8'h45, 8'h12};
  logic [1:0]  bf [6] = '{2'b00, 2'b00, 2'b01, 2'b00, 2'b10, 2'b00};
  logic [7:0]  dop [4] = '{8'h14, 8'h15, 8'h1f, 8'h17};
  logic [7:0]  dm [4] = '{8'h00, 8'h00, 8'h80, 8'h55};
  logic [7:0]  de [4] = '{8'hff, 8'hff, 8'h7f, 8'h0f};
  logic [7:0]  va [4] = '{8'hfb, 8'h07, 8'hff, 8'h3c};
  logic [7:0]  vb [4] = '{8'h12, 8'h09, 8'h01, 8'h00};

  always #5 clk_sys = ~clk_sys;

  ccao_exec i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .req(req), .acc_in(acc_in),
    .helper_in(helper_in), .flags_in(flags_in), .pc_in(pc_in),
    .port_target(port_target), .wb(wb), .acc_out(acc_out),
    .acc_we(acc_we), .helper_out(helper_out), .helper_we(helper_we),
    .flags_out(flags_out), .flags_we(flags_we), .pc_out(pc_out),
    .pc_we(pc_we), .instr_bytes(instr_bytes), .done(done),
    .illegal(illegal)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // holds the request until done or illegal, counting edges
  task automatic run(input logic [7:0] o);
    req.opcode = o;
    req.valid = 1'b1;
    cyc = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      cyc++;
    end
    while (done !== 1'b1 && illegal !== 1'b1 && cyc < 12);
  endtask

  task automatic rest;
    req.valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  function automatic logic [2:0] fk();
    return (flags_we === 1'b0) ? flags_in : flags_out;
  endfunction

  function automatic logic [8:0] bcd(input logic [7:0] a,
                                     input logic c, input logic h);
    logic [8:0] t;
    t = {1'b0, a};
    if (a[3:0] > 4'h9 || h)
      t = t + 9'h006;
    c = c | t[8];
    if (t[7:4] > 4'h9 || c)
      t = {1'b0, t[7:0]} + 9'h060;
    return {c | t[8], t[7:0]};
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    chk({done, illegal, acc_we, pc_we, flags_we}, 16'h0000);
    pc_in = 16'hfffc;
    for (int k = 0; k < 4; k++)
      for (int j = 0; j < 3; j++)
      begin
        x = ca[j];
        y = cb[j];
        req.rel = (j == 2) ? 8'h7f : 8'h80;
        acc_in = (k < 2) ? x : 8'haa;
        req.mem = (k == 0) ? 8'h55 : (k == 1) ? y : x;
        req.imm = (k == 1) ? 8'h66 : y;
        run(cop[k]);
        chk(cyc[15:0], 16'h0002);
        chk(pc_out, 16'hffff + ((x != y) ? {{8{req.rel[7]}}, req.rel}
                                         : 16'h0000));
        chk({pc_we, flags_out.cy}, {1'b1, x < y});
        chk({acc_we, wb.byte_we, instr_bytes}, 5'h03);
      end
    rest;
    $display("test compare done");
    flags_in = 3'b101;
    acc_in = 8'h5c;
    run(8'he4);
    chk({acc_we, acc_out, fk(), cyc[2:0]}, {9'h100, 6'o51});
    run(8'hf4);
    chk({acc_we, acc_out, fk()}, {9'h1a3, 3'b101});
    run(8'hc3);
    chk({flags_we, flags_out, cyc[2:0]}, 7'b1001_001);
    run(8'hb3);
    chk({flags_we, flags_out, cyc[2:0]}, 7'b1001_001);
    flags_in = 3'b001;
    run(8'hb3);
    chk({flags_we, flags_out}, 4'b1101);
    req.bit_val = 1'b1;
    run(8'hc2);
    chk({wb.bit_we, wb.bit_val, instr_bytes, cyc[2:0]},
        8'b10_010_001);
    port_target = 1'b1;
    req.bit_val = 1'b0;
    req.latch = 8'h01;
    run(8'hb2);
    chk({wb.bit_we, wb.bit_val}, 2'b10);
    port_target = 1'b0;
    run(8'hb2);
    chk({wb.bit_we, wb.bit_val}, 2'b11);
    $display("test clear and complement done");
    for (int k = 0; k < 6; k++)
    begin
      acc_in = ba[k];
      flags_in = {bf[k], 1'b1};
      run(8'hd4);
      chk({flags_out.cy, acc_out},
          bcd(ba[k], bf[k][1], bf[k][0]));
      chk({flags_out.ov, cyc[2:0]}, 4'b1001);
    end
    $display("test decimal adjust done");
    flags_in = 3'b101;
    req.latch = 8'h10;
    for (int k = 0; k < 4; k++)
    begin
      acc_in = dm[k];
      req.mem = dm[k];
      port_target = (k == 3);
      run(dop[k]);
      chk((k == 0) ? {acc_we, acc_out} : {wb.byte_we, wb.byte_val},
          {1'b1, de[k]});
      chk({fk(), instr_bytes, cyc[2:0]},
          {3'b101, ((k == 1) ? 3'h2 : 3'h1), 3'h1});
    end
    $display("test decrement done");
    flags_in = 3'b100;
    for (int k = 0; k < 4; k++)
    begin
      acc_in = va[k];
      helper_in = vb[k];
      run(8'h84);
      chk({flags_out.cy, flags_out.ov, cyc[2:0]},
          {1'b0, vb[k] == 8'h00, 3'h4});
      if (vb[k] != 8'h00)
      begin
        chk({acc_out, helper_out},
            {va[k] / vb[k], va[k] % vb[k]});
        chk({acc_we, helper_we}, 2'b11);
      end
      else
        chk({acc_we, helper_we}, 2'b00);
    end
    $display("test divide done");
    run(8'ha5);
    chk({illegal, done}, 2'b10);
    rest;
    $display("test unknown opcode done");
    conclude;
  end

  initial
  begin
    repeat (2000) @(posedge clk_sys);
    n_mismatch++;
    conclude;
  end
endmodule
